// ===== hdl/dbg_brk_gen.sv
// breakpoint generation and routing for the on-chip debug unit
// Operation
// R1 - breakpoints only through the final sequencer state
// R2 - clearing armed bit never raises breakpoint
// R3 - match or event to idle may break
// R4 - force trigger enters final, breaks when disarmed
// R5 - debug mode only with controller enabled
// R6 - no breakpoints while debug mode active
// R7 - no breakpoints during single step command
// R8 - request taken at next instruction boundary
// R9 - debug request beats coincident software interrupt
// R10 - deferred software interrupt runs after return
// R11 - routing by enable, mapping, controller, mode
// R12 - host configures and arms, then unit monitors
// R13 - external event synchronised, one pulse each
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module dbg_brk_gen (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [7:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // comparator and event sources
    input wire logic comparator_match_in,
    input wire logic external_event_input_in,
    // background debug controller and cpu status
    input wire logic controller_enable_bit_in,
    input wire logic background_debug_mode_in,
    input wire logic single_step_command_in,
    input wire logic insn_boundary_in,
    input wire logic swi_at_boundary_in,
    // breakpoint requests toward the cpu
    output logic brk_swi_out,
    output logic brk_bdm_out,
    output logic swi_defer_out,
    // interrupt
    output logic irq_out
);
    import dbg_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [7:0] ctrl;            // debug_control_one
        logic [DBG_EV_NUM-1:0] stat; // sticky events
        logic [DBG_EV_NUM-1:0] mask; // interrupt enables
        dbg_seq_t seq;               // sequencer
        logic pend;                  // breakpoint waiting for boundary
        logic pend_bdm;              // pending one goes to debug mode
        logic swi_pend;              // swi deferred behind debug entry
        logic brk_swi;               // registered swi request
        logic brk_bdm;               // registered debug-mode request
        logic wr_ph;                 // write data phase pending
        logic [7:0] wr_addr;         // latched write address
        logic [31:0] rdata;          // read data
    } dbg_state_t;

    dbg_state_t st_q;
    dbg_state_t st_d;
    logic ev_pulse;      // synchronised external event
    logic force_trigger_bit_wr;       // software writes one to trigger
    logic arm_wr_val;    // armed value being written
    logic ctrl_wr;       // control register write this cycle
    logic suppress;      // breakpoints blocked
    logic route_ok_swi;  // routing table gives swi
    logic route_ok_bdm;  // routing table gives debug mode
    logic rd_req;        // read address phase accepted
    logic wr_req;        // write address phase accepted
    logic [DBG_EV_NUM-1:0] ev_set; // events this cycle

    ////////////////////////////////////////////////////////////////////
    // event input crossing
    dbg_event_sync u_sync ( // R13
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .level_in(external_event_input_in),
        .pulse_out(ev_pulse)
    );

    ////////////////////////////////////////////////////////////////////
    // bus decode: single word transfers, no wait states
    assign rd_req = hsel_in & hready_in & (htrans_in == DBG_HTRANS_NONSEQ)
                    & ~hwrite_in & (hsize_in == DBG_HSIZE_WORD);
    assign wr_req = hsel_in & hready_in & (htrans_in == DBG_HTRANS_NONSEQ)
                    & hwrite_in & (hsize_in == DBG_HSIZE_WORD);
    assign ctrl_wr = st_q.wr_ph & (st_q.wr_addr == DBG_CTRL_OFS);
    assign force_trigger_bit_wr = ctrl_wr & hwdata_in[DBG_FORCE_TRIGGER_BIT_BIT];
    assign arm_wr_val = hwdata_in[DBG_ARM_BIT];

    // blocked in debug mode or while single stepping
    assign suppress = background_debug_mode_in
                      | single_step_command_in; // R6 R7

    // routing table, debug mode inactive already folded into suppress
    assign route_ok_swi = st_q.ctrl[DBG_CPUBRK_BIT]
                          & ~st_q.ctrl[DBG_ROUTE_BIT]; // R11
    assign route_ok_bdm = st_q.ctrl[DBG_CPUBRK_BIT]
                          & st_q.ctrl[DBG_ROUTE_BIT]
                          & controller_enable_bit_in; // R11 R5

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        st_d = st_q;
        ev_set = '0;
        st_d.brk_swi = 1'b0;
        st_d.brk_bdm = 1'b0;
        st_d.wr_ph = wr_req;
        if (wr_req) begin
            st_d.wr_addr = haddr_in;
        end
        // control write; the trigger bit never stores
        if (ctrl_wr) begin
            st_d.ctrl = hwdata_in[7:0] & DBG_CTRL_WMASK; // R12
        end
        // sequencer
        case (st_q.seq)
            DBG_SEQ_IDLE: begin
                // arming only by a write that sets the armed bit
                if (ctrl_wr && arm_wr_val) begin
                    st_d.seq = DBG_SEQ_ARMED; // R12
                end
            end
            DBG_SEQ_ARMED: begin
                if (ctrl_wr && !arm_wr_val) begin
                    st_d.seq = DBG_SEQ_IDLE; // R2
                end else if (comparator_match_in || ev_pulse) begin
                    st_d.seq = DBG_SEQ_FINAL; // R1 R3
                end
            end
            DBG_SEQ_FINAL: begin
                // final state raises the request when routed and not suppressed, and returns to idle
                st_d.seq = DBG_SEQ_IDLE; // R3
                if (!suppress && (route_ok_swi || route_ok_bdm)) begin
                    st_d.pend = 1'b1; // R1
                    st_d.pend_bdm = route_ok_bdm;
                end
                st_d.ctrl[DBG_ARM_BIT] = 1'b0;
            end
            default: begin
                st_d.seq = DBG_SEQ_IDLE;
            end
        endcase
        // force trigger wins over everything, armed or not
        if (force_trigger_bit_wr) begin
            st_d.seq = DBG_SEQ_FINAL; // R4
        end
        // drop pending request if suppression appears before boundary
        if (suppress) begin
            st_d.pend = 1'b0; // R6 R7
        end
        // issue at the next instruction boundary
        if (st_q.pend && insn_boundary_in && !suppress) begin // R8
            st_d.pend = 1'b0;
            if (st_q.pend_bdm) begin
                st_d.brk_bdm = 1'b1; // R9
                ev_set[DBG_EV_BDM] = 1'b1;
                // swi at this boundary is held until debug mode ends
                st_d.swi_pend = swi_at_boundary_in; // R10
            end else begin
                st_d.brk_swi = 1'b1;
                ev_set[DBG_EV_SWI] = 1'b1;
            end
        end
        // deferred swi released once debug mode is left
        if (st_q.swi_pend && !background_debug_mode_in
            && !st_q.brk_bdm) begin
            st_d.swi_pend = 1'b0; // R10
        end
        // sticky status: write one clears, set wins
        if (st_q.wr_ph && st_q.wr_addr == DBG_STAT_OFS) begin
            st_d.stat = st_q.stat & ~hwdata_in[DBG_EV_NUM-1:0];
        end
        st_d.stat = st_d.stat | ev_set;
        if (st_q.wr_ph && st_q.wr_addr == DBG_MASK_OFS) begin
            st_d.mask = hwdata_in[DBG_EV_NUM-1:0];
        end
        // read data for the following data phase
        if (rd_req) begin
            case (haddr_in)
                DBG_CTRL_OFS: st_d.rdata = {24'h000000, st_q.ctrl};
                DBG_STAT_OFS: st_d.rdata = {30'h00000000, st_q.stat};
                DBG_MASK_OFS: st_d.rdata = {30'h00000000, st_q.mask};
                DBG_SEQ_OFS: st_d.rdata = {28'h0000000, st_q.pend,
                                           st_q.seq};
                default: st_d.rdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q.ctrl <= DBG_CTRL_RST;
            st_q.stat <= DBG_EV_RST;
            st_q.mask <= DBG_EV_RST;
            st_q.seq <= DBG_SEQ_IDLE;
            st_q.pend <= 1'b0;
            st_q.pend_bdm <= 1'b0;
            st_q.swi_pend <= 1'b0;
            st_q.brk_swi <= 1'b0;
            st_q.brk_bdm <= 1'b0;
            st_q.wr_ph <= 1'b0;
            st_q.wr_addr <= 8'h00;
            st_q.rdata <= 32'h00000000;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign hrdata_out = st_q.rdata;
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign brk_swi_out = st_q.brk_swi;
    assign brk_bdm_out = st_q.brk_bdm;
    assign swi_defer_out = st_q.swi_pend;
    assign irq_out = |(st_q.stat & st_q.mask);

    ////////////////////////////////////////////////////////////////////
    // checks
    AST_FORCE_TRIGGER_BIT_FINAL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        force_trigger_bit_wr |=> st_q.seq == DBG_SEQ_FINAL) // R4
        else $error("trigger write did not reach final state");
    AST_DISARM_NO_FINAL: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (ctrl_wr && !arm_wr_val && !force_trigger_bit_wr && st_q.seq == DBG_SEQ_ARMED)
        |=> st_q.seq == DBG_SEQ_IDLE) // R2
        else $error("disarm write moved sequencer to final");
    AST_FINAL_ONLY: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        $rose(st_q.pend) |-> $past(st_q.seq) == DBG_SEQ_FINAL) // R1
        else $error("breakpoint pending without final state");
    AST_MATCH_FINAL: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (st_q.seq == DBG_SEQ_ARMED && comparator_match_in && !ctrl_wr)
        |=> st_q.seq == DBG_SEQ_FINAL ##1 st_q.seq == DBG_SEQ_IDLE
            || st_q.seq == DBG_SEQ_FINAL) // R3
        else $error("match did not advance sequencer");
    AST_BDM_NEEDS_EN: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        brk_bdm_out |-> $past(controller_enable_bit_in)) // R5
        else $error("debug entry without controller enable");
    AST_NO_BRK_IN_BDM: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        $past(background_debug_mode_in) |-> !brk_swi_out && !brk_bdm_out) // R6
        else $error("breakpoint while debug mode active");
    AST_NO_BRK_STEP: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        $past(single_step_command_in) |-> !brk_swi_out && !brk_bdm_out) // R7
        else $error("breakpoint during single step");
    AST_AT_BOUNDARY: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (brk_swi_out || brk_bdm_out) |-> $past(insn_boundary_in)) // R8
        else $error("breakpoint off instruction boundary");
    AST_BDM_OVER_SWI: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        (st_q.pend && st_q.pend_bdm && insn_boundary_in && !suppress
         && swi_at_boundary_in) |=> brk_bdm_out && swi_defer_out) // R9 R10
        else $error("software interrupt not deferred behind debug entry");
    AST_ROUTE_OFF: assert property (@(posedge clk_in)
        disable iff (!rst_n_in)
        !st_q.ctrl[DBG_CPUBRK_BIT] && st_q.seq == DBG_SEQ_FINAL
        |=> !st_q.pend || $past(st_q.pend)) // R11
        else $error("breakpoint raised with cpu break disabled");
endmodule : dbg_brk_gen

// ===== hdl/dbg_pkg.sv
// package of constants and types for the debug breakpoint generator
package dbg_pkg;
    // register byte offsets
    localparam logic [7:0] DBG_CTRL_OFS = 8'h00;   // debug_control_one
    localparam logic [7:0] DBG_STAT_OFS = 8'h04;   // sticky event status
    localparam logic [7:0] DBG_MASK_OFS = 8'h08;   // interrupt mask
    localparam logic [7:0] DBG_SEQ_OFS = 8'h0c;    // sequencer state view
    // debug_control_one field positions
    localparam int DBG_ARM_BIT = 7;                // session armed
    localparam int DBG_FORCE_TRIGGER_BIT_BIT = 6;               // force_trigger_bit
    localparam int DBG_ROUTE_BIT = 4;              // route_to_debug_mode_bit
    localparam int DBG_CPUBRK_BIT = 3;             // cpu_break_enable
    localparam logic [7:0] DBG_CTRL_RST = 8'h00;   // control reset value
    localparam logic [7:0] DBG_CTRL_WMASK = 8'h98; // writable, force_trigger_bit self-clears
    // status bit positions
    localparam int DBG_EV_SWI = 0;                 // swi breakpoint issued
    localparam int DBG_EV_BDM = 1;                 // debug-mode breakpoint issued
    localparam int DBG_EV_NUM = 2;                 // number of events
    localparam logic [1:0] DBG_EV_RST = 2'h0;      // status and mask reset
    // ahb-lite codes
    localparam logic [1:0] DBG_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] DBG_HSIZE_WORD = 3'h2;
    // sequencer states, one-hot
    typedef enum logic [2:0] {
        DBG_SEQ_IDLE = 3'h1,   // idle_sequencer_state
        DBG_SEQ_ARMED = 3'h2,  // watching for a match or event
        DBG_SEQ_FINAL = 3'h4   // final state, breakpoint raised if routed and not suppressed
    } dbg_seq_t;
endpackage : dbg_pkg

// ===== hdl/dbg_event_sync.sv
// two-stage synchroniser with one-pulse edge detect for the event input
`timescale 1ns/1ps
module dbg_event_sync (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // raw level in, one pulse out
    input wire logic level_in,
    output logic pulse_out
);
    import dbg_pkg::*;

    // all state in one struct
    typedef struct packed {
        logic s1;   // first stage, read only by s2
        logic s2;   // second stage
        logic s3;   // previous s2 for the edge
    } dbg_sync_t;

    dbg_sync_t st_q;
    dbg_sync_t st_d;

    // next state: pure shift
    always_comb begin
        st_d = st_q;
        st_d.s1 = level_in;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
    end

    // register the state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // one pulse per rising edge, so one assertion is one event
    assign pulse_out = st_q.s2 & ~st_q.s3;
endmodule : dbg_event_sync

// ===== testbench/dbg_cpu_model.sv
// cpu core and debug controller model facing the breakpoint outputs
`timescale 1ns/1ps
module dbg_cpu_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // requests from the block, bench controls
    input wire logic brk_bdm_in,
    input wire logic swi_next_in,
    input wire logic hold_bdm_in,
    // cpu and controller status toward the block
    output logic insn_boundary_out,
    output logic swi_at_boundary_out,
    output logic background_debug_mode_out
);
    logic [1:0] phase_q; // boundary every fourth cycle
    logic [2:0] bdm_cnt_q; // cycles left in debug mode
    ////////////////////////////////////////////////////////////////////////
    // instruction pacing and debug mode stay
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= 2'h0;
            bdm_cnt_q <= 3'h0;
        end else begin
            phase_q <= phase_q + 2'h1;
            if (brk_bdm_in) begin
                bdm_cnt_q <= 3'h6;
            end else if (bdm_cnt_q != 3'h0) begin
                // deferred swi runs once this reaches zero
                bdm_cnt_q <= bdm_cnt_q - 3'h1;
            end
        end
    end
    assign insn_boundary_out = (phase_q == 2'h3);
    // swi flag only qualifies a boundary, low elsewhere
    assign swi_at_boundary_out = swi_next_in && insn_boundary_out;
    // bench may hold debug mode to mimic a host session
    assign background_debug_mode_out = hold_bdm_in || (bdm_cnt_q != 3'h0);
endmodule : dbg_cpu_model

// ===== testbench/tb_top.sv
// self-checking bench for the breakpoint generator
`timescale 1ns/1ps
`define CHK(a, e) begin \
    cmp_count++; \
    if ((a) !== (e)) begin \
        n_errors++; \
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
    end \
end
module tb_top;
    import dbg_pkg::*;
    logic clk_in, rst_n_in, hsel, hwrite, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, seed, rd;
    logic match, ev, ctl_en, step, boundary, swi_at, background_debug_mode;
    logic swi_next, hold_bdm, brk_swi, brk_bdm, defer, irq;
    logic [1:0] exp_q[$]; // expected {bdm, swi} per request
    logic [1:0] e;
    logic [1:0] mon_e; // monitor's own copy of the oldest note
    int n_errors, cmp_count, i;
    logic [7:0] offs[5] = '{DBG_CTRL_OFS, DBG_STAT_OFS, DBG_MASK_OFS,
        DBG_SEQ_OFS, 8'h40};
    logic [31:0] rst_v[5] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h0};
    dbg_brk_gen i_dbg_brk_gen (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata),
        .hreadyout_out(hreadyout), .hresp_out(hresp),
        .comparator_match_in(match), .external_event_input_in(ev),
        .controller_enable_bit_in(ctl_en),
        .background_debug_mode_in(background_debug_mode), .single_step_command_in(step),
        .insn_boundary_in(boundary), .swi_at_boundary_in(swi_at),
        .brk_swi_out(brk_swi), .brk_bdm_out(brk_bdm),
        .swi_defer_out(defer), .irq_out(irq));
    dbg_cpu_model i_dbg_cpu_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .brk_bdm_in(brk_bdm), .swi_next_in(swi_next),
        .hold_bdm_in(hold_bdm), .insn_boundary_out(boundary),
        .swi_at_boundary_out(swi_at), .background_debug_mode_out(background_debug_mode));
    ////////////////////////////////////////////////////////////////////////
    // clock, 100 ns period
    initial begin
        clk_in = 1'b0;
        forever #50 clk_in = ~clk_in;
    end
    // xorshift source, fixed start
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic finish_test();
        $display("errors=%0d compares=%0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    // bounded wait for hready, a hang ends the run
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_in);
            if (hreadyout === 1'b1) return;
        end
        n_errors++;
        finish_test();
    endtask : wait_rdy
    // one single word transfer, address then data phase
    task automatic bus(input logic wr, input logic [7:0] a,
            input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= DBG_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        r = hrdata;
    endtask : bus
    // long enough for a boundary, a request and a debug stay
    task automatic settle();
        repeat (20) @(posedge clk_in);
        `CHK(exp_q.size(), 0)
    endtask : settle
    task automatic wait_defer(input logic v);
        int n;
        for (n = 0; n < 40 && defer !== v; n++) @(negedge clk_in);
        `CHK(defer, v)
    endtask : wait_defer
    ////////////////////////////////////////////////////////////////////////
    // monitor: every request pulse takes the oldest note
    always @(negedge clk_in) begin
        if (brk_swi === 1'b1 || brk_bdm === 1'b1) begin
            mon_e = (exp_q.size() != 0) ? exp_q.pop_front() : 2'h0;
            `CHK({brk_bdm, brk_swi}, mon_e)
        end
    end
    // global limit on run length
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {hsel, hwrite, match, ev, ctl_en, step, swi_next, hold_bdm} = '0;
        {haddr, htrans, hwdata, n_errors, cmp_count} = '0;
        hsize = DBG_HSIZE_WORD;
        seed = 32'h04027572;
        rst_n_in = 1'b0;
        repeat (4) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        `CHK({brk_swi, brk_bdm, defer, irq, hreadyout, hresp}, 6'h02)
        for (i = 0; i < 5; i++) begin
            bus(1'b0, offs[i], 32'h0, rd);
            `CHK(rd, rst_v[i])
        end
        // routing table, forced trigger while disarmed
        for (i = 0; i < 8; i++) begin
            ctl_en <= i[2];
            e = !i[0] ? 2'h0 : (!i[1] ? 2'h1 : (i[2] ? 2'h2 : 2'h0));
            if (e != 2'h0) exp_q.push_back(e);
            bus(1'b1, DBG_CTRL_OFS, {24'h0, 2'h1, 1'b0, i[1], i[0], 3'h0},
                rd);
            settle();
            bus(1'b0, DBG_STAT_OFS, 32'h0, rd);
            `CHK(rd, {30'h0, e})
            bus(1'b1, DBG_STAT_OFS, 32'h3, rd);
        end
        // armed session, comparator hit routed to debug mode
        exp_q.push_back(2'h2);
        bus(1'b1, DBG_CTRL_OFS, 32'h98, rd);
        match <= 1'b1;
        @(posedge clk_in);
        match <= 1'b0;
        settle();
        // armed, one external event of random width gives one swi
        exp_q.push_back(2'h1);
        bus(1'b1, DBG_CTRL_OFS, 32'h88, rd);
        ev <= 1'b1;
        repeat (1 + rnd() % 32'h6) @(posedge clk_in);
        ev <= 1'b0;
        settle();
        // disarming write must stay silent
        bus(1'b1, DBG_CTRL_OFS, 32'h88, rd);
        bus(1'b1, DBG_CTRL_OFS, 32'h08, rd);
        settle();
        // suppression by debug mode, then by single step
        hold_bdm <= 1'b1;
        bus(1'b1, DBG_CTRL_OFS, 32'h58, rd);
        settle();
        hold_bdm <= 1'b0;
        step <= 1'b1;
        bus(1'b1, DBG_CTRL_OFS, 32'h48, rd);
        settle();
        step <= 1'b0;
        // swi at the boundary loses to debug mode, runs after return
        swi_next <= 1'b1;
        exp_q.push_back(2'h2);
        bus(1'b1, DBG_CTRL_OFS, 32'h58, rd);
        wait_defer(1'b1);
        swi_next <= 1'b0;
        wait_defer(1'b0);
        settle();
        // interrupt under a random mask, then cleared
        // both status bits are set here: swi from the event, bdm above
        e = 2'(rnd() % 32'h4);
        bus(1'b1, DBG_MASK_OFS, {30'h0, e}, rd);
        @(negedge clk_in);
        `CHK(irq, |e)
        bus(1'b1, DBG_STAT_OFS, 32'h3, rd);
        @(negedge clk_in);
        `CHK(irq, 1'b0)
        finish_test();
    end
endmodule : tb_top
